// ### hdl/scr_pkg.sv
// Package of offsets, fields, reset values and limit codes for the supply control registers
`default_nettype none
package scr_pkg;
    localparam logic [15:0] OFF_RNG_DATA    = 16'h6105;
    localparam logic [15:0] OFF_SWITCH      = 16'h6106;
    localparam logic [15:0] OFF_REGULATOR   = 16'h6109;
    localparam logic [15:0] REG_IDX_BASE    = 16'h6100;
    localparam logic [11:0] ADDR_RNG_DATA   = 12'h014;
    localparam logic [11:0] ADDR_SWITCH     = 12'h018;
    localparam logic [11:0] ADDR_REGULATOR  = 12'h024;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h040;
    localparam logic [11:0] ADDR_IRQ_MASK   = 12'h044;
    localparam int SW_HIDE      = 6;
    localparam int SW_OVERLOAD  = 5;
    localparam int SW_EN        = 4;
    localparam int SW_NEED_RNG  = 2;
    localparam int SW_READY     = 1;
    localparam int SW_RSVD0     = 0;
    localparam int REG_OC_STAT  = 5;
    localparam int REG_SEL_LO   = 3;
    localparam int REG_OFFSET   = 2;
    localparam int REG_SOFT_HS  = 1;
    localparam int REG_CTRL_HS  = 0;
    localparam int IRQ_OC       = 0;
    localparam int IRQ_RNG      = 1;
    localparam int IRQ_OVERLOAD = 2;
    localparam int IRQ_W        = 3;
    localparam logic       RST_HIDE     = 1'b1;
    localparam logic       RST_OFFSET   = 1'b1;
    localparam logic       RST_SW_EN    = 1'b0;
    localparam logic       RST_NEED_RNG = 1'b0;
    localparam logic       RST_SOFT_HS  = 1'b0;
    localparam logic       RST_CTRL_HS  = 1'b0;
    localparam logic [1:0] RST_SEL      = 2'h0;
    localparam logic [1:0] SEL_300MA    = 2'h0;
    localparam logic [1:0] SEL_210MA    = 2'h1;
    localparam logic [1:0] SEL_180MA    = 2'h2;
    localparam logic [1:0] SEL_150MA    = 2'h3;
endpackage : scr_pkg
`default_nettype wire

// ### hdl/scr_sync.sv
// Two-flop synchroniser bank for asynchronous status inputs
`default_nettype none
module scr_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    input  wire logic [W-1:0] rst_val,
    output var  logic [W-1:0] q
);
    logic [W-1:0] s1_reg;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    s1_reg[i] <= 1'b0;
                    q[i]      <= 1'b0;
                end else begin
                    s1_reg[i] <= d[i];
                    q[i]      <= s1_reg[i];
                end
            end
        end
    endgenerate
endmodule : scr_sync
`default_nettype wire

// ### hdl/scr_top.sv
// Supply control register bank with APB slave and interrupt
//
// Decided for this implementation: the APB slave port.
`default_nettype none
module scr_top (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        oc_300ma,
    input  wire logic        oc_210ma,
    input  wire logic        oc_180ma,
    input  wire logic        oc_150ma,
    input  wire logic        switch_limit_active,
    input  wire logic        rf_detected,
    input  wire logic        secure_signal_pad,
    input  wire logic        port3_bit4_pad,
    input  wire logic        contactless_unit_rng_run,
    input  wire logic        rng_new_value,
    input  wire logic [7:0]  rng_value,
    input  wire logic        overcurrent_irq_enable,
    output var  logic [1:0]  oc_limit_sel,
    output var  logic        regulator_offset_en,
    output var  logic        regulator_high_bw,
    output var  logic        secure_supply_en,
    output var  logic        secure_signal_in,
    output var  logic        port3_bit4_input,
    output var  logic        rng_run,
    output var  logic        overcurrent_irq,
    output var  logic        irq
);
    logic [6:0] async_s;
    logic [6:0] zero7;
    logic       oc_150_s;
    logic       oc_180_s;
    logic       oc_210_s;
    logic       oc_300_s;
    logic       limit_s;
    logic       rf_s;
    logic       sig_s;
    logic       p34_s;

    assign zero7 = 7'h00;

    scr_sync #(.W(7)) u_sync (
        .clk     (clk),
        .rst_b   (rst_b),
        .d       ({oc_300ma, oc_210ma, oc_180ma, oc_150ma,
                   switch_limit_active, rf_detected, secure_signal_pad}),
        .rst_val (zero7),
        .q       (async_s)
    );

    assign {oc_300_s, oc_210_s, oc_180_s, oc_150_s, limit_s, rf_s, sig_s} = async_s;

    // Port bit pad synchronised separately to reset high
    logic p34_s1_reg;
    logic p34_s2_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            p34_s1_reg <= 1'b1;
            p34_s2_reg <= 1'b1;
        end else begin
            p34_s1_reg <= port3_bit4_pad;
            p34_s2_reg <= p34_s1_reg;
        end
    end
    assign p34_s = p34_s2_reg;

    // Control registers
    logic       hide_reg;
    logic       sw_en_reg;
    logic       need_rng_reg;
    logic       ready_reg;
    logic [1:0] sel_reg;
    logic       offset_reg;
    logic       soft_hs_reg;
    logic       ctrl_hs_reg;
    logic       oc_stat_reg;
    logic       overload_reg;

    // Bus decode
    wire        access_ph = psel & penable;
    wire        setup_ph  = psel & ~penable;
    wire        wr_en     = access_ph & pwrite & pstrb[0];
    wire        rd_en     = access_ph & ~pwrite;
    wire        hit_rng   = (paddr == scr_pkg::ADDR_RNG_DATA);
    wire        hit_sw    = (paddr == scr_pkg::ADDR_SWITCH);
    wire        hit_reg   = (paddr == scr_pkg::ADDR_REGULATOR);
    wire        hit_ist   = (paddr == scr_pkg::ADDR_IRQ_STATUS);
    wire        hit_imk   = (paddr == scr_pkg::ADDR_IRQ_MASK);
    wire        mapped    = hit_rng | hit_sw | hit_reg | hit_ist | hit_imk;
    wire        wr_sw     = wr_en & hit_sw;
    wire        wr_reg    = wr_en & hit_reg;
    wire        rng_rd    = rd_en & hit_rng;
    wire        ist_clr   = wr_en & hit_ist;
    wire        imk_wr    = wr_en & hit_imk;

    // Detector selected by limit field
    wire        oc_detect = (sel_reg == scr_pkg::SEL_300MA) ? oc_300_s :
                            (sel_reg == scr_pkg::SEL_210MA) ? oc_210_s :
                            (sel_reg == scr_pkg::SEL_180MA) ? oc_180_s :
                                                               oc_150_s;

    // Data valid: new value wins over a read in the same cycle
    wire        ready_next = rng_new_value ? 1'b1 :
                             (rng_rd ? 1'b0 :
                              (wr_sw ? pwdata[scr_pkg::SW_READY] : ready_reg));

    // Sticky events on rising edges of the live flags and on each new generator value
    logic [scr_pkg::IRQ_W-1:0] irq_stat_reg;
    logic [scr_pkg::IRQ_W-1:0] irq_mask_reg;
    logic [scr_pkg::IRQ_W-1:0] irq_evt;
    logic [scr_pkg::IRQ_W-1:0] irq_clr;
    logic [scr_pkg::IRQ_W-1:0] irq_stat_next;
    logic [scr_pkg::IRQ_W-1:0] irq_hit;

    always_comb begin
        irq_evt                        = '0;
        irq_evt[scr_pkg::IRQ_OC]       = ~oc_stat_reg & oc_detect;
        irq_evt[scr_pkg::IRQ_RNG]      = rng_new_value;
        irq_evt[scr_pkg::IRQ_OVERLOAD] = ~overload_reg & limit_s;
    end

    assign irq_clr       = ist_clr ? pwdata[scr_pkg::IRQ_W-1:0] : '0;
    assign irq_stat_next = irq_evt | (irq_stat_reg & ~irq_clr);
    assign irq_hit       = irq_stat_next & irq_mask_reg;

    // Read-back images built from the field positions
    logic [7:0] sw_rd;
    logic [7:0] reg_rd;

    always_comb begin
        sw_rd                       = 8'h00;
        sw_rd[scr_pkg::SW_RSVD0]    = 1'b1;
        sw_rd[scr_pkg::SW_HIDE]     = hide_reg;
        sw_rd[scr_pkg::SW_OVERLOAD] = overload_reg;
        sw_rd[scr_pkg::SW_EN]       = sw_en_reg;
        sw_rd[scr_pkg::SW_NEED_RNG] = need_rng_reg;
        sw_rd[scr_pkg::SW_READY]    = ready_reg;
    end

    always_comb begin
        reg_rd                           = 8'h00;
        reg_rd[scr_pkg::REG_OC_STAT]     = oc_stat_reg;
        reg_rd[scr_pkg::REG_SEL_LO +: 2] = sel_reg;
        reg_rd[scr_pkg::REG_OFFSET]      = offset_reg;
        reg_rd[scr_pkg::REG_SOFT_HS]     = soft_hs_reg;
        reg_rd[scr_pkg::REG_CTRL_HS]     = ctrl_hs_reg;
    end

    wire [31:0] rd_mux = hit_rng ? {24'h000000, rng_value} :
                         hit_sw  ? {24'h000000, sw_rd} :
                         hit_reg ? {24'h000000, reg_rd} :
                         hit_ist ? {29'h00000000, irq_stat_reg} :
                         hit_imk ? {29'h00000000, irq_mask_reg} : 32'h00000000;

    // Output next values
    wire        high_bw_next = ctrl_hs_reg ? soft_hs_reg : ~rf_s;
    wire        sig_in_next  = hide_reg ? 1'b0 : sig_s;
    wire        p34_in_next  = hide_reg ? 1'b1 : p34_s;
    wire        rng_run_next = need_rng_reg | contactless_unit_rng_run;
    wire        oc_irq_next  = oc_stat_reg & overcurrent_irq_enable;

    // Switch register writes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hide_reg     <= scr_pkg::RST_HIDE;
            sw_en_reg    <= scr_pkg::RST_SW_EN;
            need_rng_reg <= scr_pkg::RST_NEED_RNG;
        end else if (wr_sw) begin
            hide_reg     <= pwdata[scr_pkg::SW_HIDE];
            sw_en_reg    <= pwdata[scr_pkg::SW_EN];
            need_rng_reg <= pwdata[scr_pkg::SW_NEED_RNG];
        end
    end

    // Regulator register writes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_reg     <= scr_pkg::RST_SEL;
            offset_reg  <= scr_pkg::RST_OFFSET;
            soft_hs_reg <= scr_pkg::RST_SOFT_HS;
            ctrl_hs_reg <= scr_pkg::RST_CTRL_HS;
        end else if (wr_reg) begin
            sel_reg     <= pwdata[scr_pkg::REG_SEL_LO +: 2];
            offset_reg  <= pwdata[scr_pkg::REG_OFFSET];
            soft_hs_reg <= pwdata[scr_pkg::REG_SOFT_HS];
            ctrl_hs_reg <= pwdata[scr_pkg::REG_CTRL_HS];
        end
    end

    // Live flags follow their detectors
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            oc_stat_reg  <= 1'b0;
            overload_reg <= 1'b0;
        end else begin
            oc_stat_reg  <= oc_detect;
            overload_reg <= limit_s;
        end
    end

    // Data valid flag
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= ready_next;
        end
    end

    // Sticky status, set wins over clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    // Interrupt mask
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_mask_reg <= '0;
        end else if (imk_wr) begin
            irq_mask_reg <= pwdata[scr_pkg::IRQ_W-1:0];
        end
    end

    // Regulator outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            oc_limit_sel        <= scr_pkg::RST_SEL;
            regulator_offset_en <= scr_pkg::RST_OFFSET;
            regulator_high_bw   <= 1'b0;
        end else begin
            oc_limit_sel        <= sel_reg;
            regulator_offset_en <= offset_reg;
            regulator_high_bw   <= high_bw_next;
        end
    end

    // Switch and generator outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            secure_supply_en <= scr_pkg::RST_SW_EN;
            secure_signal_in <= 1'b0;
            port3_bit4_input <= 1'b1;
            rng_run          <= 1'b0;
        end else begin
            secure_supply_en <= sw_en_reg;
            secure_signal_in <= sig_in_next;
            port3_bit4_input <= p34_in_next;
            rng_run          <= rng_run_next;
        end
    end

    // Interrupt outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            overcurrent_irq <= 1'b0;
            irq             <= 1'b0;
        end else begin
            overcurrent_irq <= oc_irq_next;
            irq             <= |irq_hit;
        end
    end

    // APB answer: one access cycle, registered data
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup_ph;
            pslverr <= setup_ph & ~mapped;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h00000000;
        end else begin
            prdata <= (setup_ph & ~pwrite) ? rd_mux : 32'h00000000;
        end
    end
endmodule : scr_top
`default_nettype wire

// ### test/scr_assertions.sv
// Concurrent checks on the supply control register bank ports
`default_nettype none
module scr_assertions (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        overcurrent_irq_enable,
    input wire logic        overcurrent_irq,
    input wire logic        contactless_unit_rng_run,
    input wire logic        rng_run,
    input wire logic        secure_signal_pad,
    input wire logic        secure_signal_in,
    input wire logic [1:0]  oc_limit_sel,
    input wire logic        regulator_offset_en,
    input wire logic        regulator_high_bw,
    input wire logic        secure_supply_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_wr(a);
        psel && penable && pready && pwrite && pstrb[0] && paddr == a;
    endsequence
    sequence s_rd(a);
        psel && penable && pready && !pwrite && paddr == a;
    endsequence
    property p_limit;
        s_wr(scr_pkg::ADDR_REGULATOR) |-> ##2 oc_limit_sel == $past(pwdata[4:3], 2)
            && regulator_offset_en == $past(pwdata[2], 2);
    endproperty
    a_limit: assert property (p_limit) else $error("limit or offset not stored");
    property p_soft_bw;
        s_wr(scr_pkg::ADDR_REGULATOR) ##0 pwdata[0] |-> ##2 regulator_high_bw == $past(pwdata[1], 2);
    endproperty
    a_soft_bw: assert property (p_soft_bw) else $error("software speed ignored");
    property p_supply;
        s_wr(scr_pkg::ADDR_SWITCH) |-> ##2 secure_supply_en == $past(pwdata[4], 2);
    endproperty
    a_supply: assert property (p_supply) else $error("supply enable wrong");
    property p_irq_gate;
        overcurrent_irq |-> $past(overcurrent_irq_enable);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enable");
    property p_sig_in;
        secure_signal_in |-> $past(secure_signal_pad, 3);
    endproperty
    a_sig_in: assert property (p_sig_in) else $error("signal input high without pad");
    property p_rng_run;
        contactless_unit_rng_run |=> rng_run;
    endproperty
    a_rng_run: assert property (p_rng_run) else $error("generator not running");
    property p_rsvd_sw;
        s_rd(scr_pkg::ADDR_SWITCH) |-> prdata[0] && prdata[31:7] == '0 && !prdata[3];
    endproperty
    a_rsvd_sw: assert property (p_rsvd_sw) else $error("switch reserved bits wrong");
    property p_rsvd_reg;
        s_rd(scr_pkg::ADDR_REGULATOR) |-> prdata[31:6] == '0;
    endproperty
    a_rsvd_reg: assert property (p_rsvd_reg) else $error("regulator reserved bits set");
endmodule : scr_assertions
bind scr_top scr_assertions scr_assertions_i (.clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .overcurrent_irq_enable, .overcurrent_irq,
    .contactless_unit_rng_run, .rng_run, .secure_signal_pad, .secure_signal_in, .oc_limit_sel,
    .regulator_offset_en, .regulator_high_bw, .secure_supply_en);
`default_nettype wire

// ### test/testbench.sv
// Self-checking testbench for the supply control register bank
`default_nettype none
`define CK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
    $display("wrong value t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [11:0] a; logic [7:0] w; logic [7:0] x; logic e;} scr_row_t;
    logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, e, irq, overcurrent_irq;
    logic        oc_300ma, oc_210ma, oc_180ma, oc_150ma, switch_limit_active, rf_detected;
    logic        secure_signal_pad, port3_bit4_pad, contactless_unit_rng_run, rng_new_value;
    logic        overcurrent_irq_enable, regulator_offset_en, regulator_high_bw, rng_run;
    logic        secure_supply_en, secure_signal_in, port3_bit4_input;
    logic [1:0]  oc_limit_sel;
    logic [7:0]  rng_value;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0]  pstrb = 4'hf;
    int          n_errors = 0;
    int          checks_done = 0;
    scr_row_t    rows[6] = '{'{scr_pkg::ADDR_REGULATOR, 8'hff, 8'h1f, 1'b0},
        '{scr_pkg::ADDR_REGULATOR, 8'h00, 8'h00, 1'b0}, '{scr_pkg::ADDR_SWITCH, 8'hff, 8'h57, 1'b0},
        '{scr_pkg::ADDR_SWITCH, 8'h00, 8'h01, 1'b0}, '{12'h100, 8'hff, 8'h00, 1'b1},
        '{scr_pkg::ADDR_IRQ_MASK, 8'hff, 8'h07, 1'b0}};
    scr_top scr_top_i (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .oc_300ma, .oc_210ma, .oc_180ma, .oc_150ma, .switch_limit_active,
        .rf_detected, .secure_signal_pad, .port3_bit4_pad, .contactless_unit_rng_run,
        .rng_new_value, .rng_value, .overcurrent_irq_enable, .oc_limit_sel, .regulator_offset_en,
        .regulator_high_bw, .secure_supply_en, .secure_signal_in, .port3_bit4_input, .rng_run,
        .overcurrent_irq, .irq);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask : w
    task automatic xf(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        for (int i = 0; i < 9 && pready !== 1'b1; i++) @(posedge clk);
        if (pready !== 1'b1) begin
            n_errors++;
            close_out();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xf
    task automatic ck(input logic [11:0] a, input logic [7:0] x);
        xf(1'b0, a, 8'h00);
        `CK(r, {24'h0, x})
    endtask : ck
    initial begin
        {rst_b, psel, penable, pwrite, paddr, pwdata, rng_value, rng_new_value} = '0;
        {oc_300ma, oc_210ma, oc_180ma, oc_150ma, switch_limit_active, rf_detected} = '0;
        {secure_signal_pad, port3_bit4_pad, contactless_unit_rng_run, overcurrent_irq_enable} = '0;
        w(6);
        rst_b <= 1'b1;
        foreach (rows[k]) begin
            xf(1'b1, rows[k].a, rows[k].w);
            xf(1'b0, rows[k].a, 8'h00);
            `CK({e, r[7:0]}, {rows[k].e, rows[k].x})
        end
        rst_b <= 1'b0;
        secure_signal_pad <= 1'b1;
        w(2);
        rst_b <= 1'b1;
        ck(scr_pkg::ADDR_REGULATOR, 8'h04);
        ck(scr_pkg::ADDR_SWITCH, 8'h41);
        `CK({regulator_offset_en, secure_signal_in, port3_bit4_input}, 3'b101)
        pstrb <= 4'h0;
        xf(1'b1, scr_pkg::ADDR_REGULATOR, 8'h00);
        pstrb <= 4'hf;
        ck(scr_pkg::ADDR_REGULATOR, 8'h04);
        xf(1'b1, scr_pkg::ADDR_SWITCH, 8'h10);
        w(5);
        `CK({secure_supply_en, secure_signal_in, port3_bit4_input}, 3'b110)
        xf(1'b1, scr_pkg::ADDR_IRQ_MASK, 8'h04);
        switch_limit_active <= 1'b1;
        w(5);
        ck(scr_pkg::ADDR_SWITCH, 8'h31);
        `CK(irq, 1'b1)
        switch_limit_active <= 1'b0;
        w(5);
        `CK(irq, 1'b1)
        ck(scr_pkg::ADDR_SWITCH, 8'h11);
        xf(1'b1, scr_pkg::ADDR_IRQ_STATUS, 8'h04);
        w(1);
        `CK(irq, 1'b0)
        rng_value <= 8'ha5;
        rng_new_value <= 1'b1;
        w(1);
        rng_new_value <= 1'b0;
        w(2);
        `CK(irq, 1'b0)
        ck(scr_pkg::ADDR_SWITCH, 8'h13);
        ck(scr_pkg::ADDR_RNG_DATA, 8'ha5);
        ck(scr_pkg::ADDR_SWITCH, 8'h11);
        for (int s = 0; s < 4; s++) begin
            overcurrent_irq_enable <= s[0];
            xf(1'b1, scr_pkg::ADDR_REGULATOR, {3'h0, s[1:0], 3'h0});
            {oc_150ma, oc_180ma, oc_210ma, oc_300ma} <= ~(4'h1 << s);
            w(6);
            ck(scr_pkg::ADDR_REGULATOR, {3'h0, s[1:0], 3'h0});
            `CK(oc_limit_sel, s[1:0])
            {oc_150ma, oc_180ma, oc_210ma, oc_300ma} <= 4'h1 << s;
            w(6);
            ck(scr_pkg::ADDR_REGULATOR, {3'h1, s[1:0], 3'h0});
            `CK(overcurrent_irq, s[0])
        end
        {oc_150ma, oc_180ma, oc_210ma, oc_300ma} <= 4'h0;
        xf(1'b1, scr_pkg::ADDR_IRQ_MASK, 8'h03);
        ck(scr_pkg::ADDR_IRQ_STATUS, 8'h03);
        `CK(irq, 1'b1)
        xf(1'b1, scr_pkg::ADDR_IRQ_STATUS, 8'h03);
        ck(scr_pkg::ADDR_IRQ_STATUS, 8'h00);
        `CK(irq, 1'b0)
        for (int j = 0; j < 4; j++) begin
            rf_detected <= (j == 2);
            xf(1'b1, scr_pkg::ADDR_REGULATOR, (j < 2) ? {6'h0, j[0], 1'b1} : 8'h00);
            w(6);
            `CK(regulator_high_bw, j[0])
        end
        xf(1'b1, scr_pkg::ADDR_SWITCH, 8'h04);
        w(2);
        `CK(rng_run, 1'b1)
        xf(1'b1, scr_pkg::ADDR_SWITCH, 8'h00);
        contactless_unit_rng_run <= 1'b1;
        w(3);
        `CK(rng_run, 1'b1)
        contactless_unit_rng_run <= 1'b0;
        w(3);
        `CK(rng_run, 1'b0)
        close_out();
    end
endmodule : testbench
`default_nettype wire
